// [core/csc_target.sv]
// Serial configuration target of a clock synthesizer: two-wire slave,
// volatile register bytes, EEPROM image copy and select-pin decoding.
// Assumes scl/sda already synchronous to clock_in (oversampled).
`timescale 1ns/100ps
`default_nettype none
module csc_target
  import csc_pkg::*;
(
  // Clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  // Serial pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe_n_out,
  // Control pins and supply state
  input  wire logic       dedicated_select_pin_in,
  input  wire logic       vddout_grounded_in,
  input  wire logic       eeprom_write_start_in,
  // Control outputs
  output var  csc_sel_t   select_out,
  output var  logic       eeprom_write_busy_flag_out
);
  //////////////////////////////////////////////////////////////////////
  typedef enum {ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_RDATA,
                ST_ACK, ST_RACK, ST_SKIP} csc_state_t;

  logic [7:0]  regs_reg   [REG_BYTES];
  // Non-volatile: blank at power-up, untouched by reset
  logic [7:0]  eeprom_reg [REG_BYTES] = '{default: 8'h00};
  csc_state_t  st_reg, st_after_reg;
  logic [7:0]  sh_reg;
  logic [3:0]  bit_reg;
  logic [6:0]  ptr_reg;
  logic        single_reg, acking_reg;
  logic        scl_d_reg, sda_d_reg;
  logic [12:0] ee_cnt_reg;
  logic        ee_busy_reg;
  logic        load_reg;
  logic [6:0]  load_idx_reg;
  logic [7:0]  rcount_reg;
  csc_sda_t    sda_reg;

  // Power-up image load: model a pristine factory image
  function automatic logic [7:0] factory_byte(input logic [6:0] idx);
    factory_byte = (idx == OFS_ID) ? ID_VALUE :
                   (idx == OFS_BYTECOUNT) ? RST_BYTECOUNT : 8'h00;
  endfunction : factory_byte

  //////////////////////////////////////////////////////////////////////
  // Pin function follows the stored image and vddout_grounded_in only
  wire       pins_ctl   = eeprom_reg[OFS_PINCTL][POS_PINMODE];
  wire       serial_ok  = !pins_ctl || vddout_grounded_in;
  wire       scl_rise   = serial_ok && scl_in && !scl_d_reg;
  wire       scl_fall   = serial_ok && !scl_in && scl_d_reg;
  wire       start_cond = serial_ok && scl_in && scl_d_reg &&
                          sda_d_reg && !sda_in;
  wire       stop_cond  = serial_ok && scl_in && scl_d_reg &&
                          !sda_d_reg && sda_in;
  wire [6:0] my_addr    = {ADDR_UPPER,
                           regs_reg[OFS_STATUS][POS_ADDR_LSB +: 2]};
  wire [7:0] sh_next    = {sh_reg[6:0], sda_in};
  wire       addr_hit   = sh_reg[7:1] == my_addr;
  wire [7:0] rd_byte    = (ptr_reg == OFS_STATUS) ?
                          {regs_reg[OFS_STATUS][7], ee_busy_reg,
                           regs_reg[OFS_STATUS][5:0]} :
                          regs_reg[ptr_reg];
  wire [7:0] byte_cnt   = regs_reg[OFS_BYTECOUNT];

  //////////////////////////////////////////////////////////////////////
  // EEPROM write cycle and power-up load
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      ee_busy_reg  <= 1'b0;
      ee_cnt_reg   <= 13'h0000;
      load_reg     <= 1'b1;
      load_idx_reg <= 7'h00;
    end else begin
      if (load_reg) begin
        load_idx_reg <= load_idx_reg + 7'h01;
        load_reg     <= load_idx_reg != 7'h7F;
      end
      if (eeprom_write_start_in && !ee_busy_reg && !load_reg) begin
        ee_busy_reg <= 1'b1;
        ee_cnt_reg  <= 13'(EE_WRITE_CYCLES - 1);
      end else if (ee_busy_reg) begin
        ee_cnt_reg  <= ee_cnt_reg - 13'h0001;
        ee_busy_reg <= ee_cnt_reg != 13'h0000;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (eeprom_write_start_in && !ee_busy_reg && !load_reg)
      eeprom_reg <= regs_reg;
    // ID byte stays blank so the factory choice holds for the whole load
    else if (load_reg && rst_in == 1'b0 && eeprom_reg[OFS_ID] == 8'h00 &&
             load_idx_reg != OFS_ID)
      eeprom_reg[load_idx_reg] <= factory_byte(load_idx_reg);
  end

  //////////////////////////////////////////////////////////////////////
  // Serial engine
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st_reg      <= ST_IDLE;
      st_after_reg <= ST_IDLE;
      sh_reg      <= 8'h00;
      bit_reg     <= 4'h0;
      ptr_reg     <= 7'h00;
      single_reg  <= 1'b0;
      acking_reg  <= 1'b0;
      scl_d_reg   <= 1'b1;
      sda_d_reg   <= 1'b1;
      rcount_reg  <= 8'h00;
      sda_reg     <= '{data_out: 1'b1, data_oe_n: 1'b1};
    end else begin
      scl_d_reg <= scl_in;
      sda_d_reg <= sda_in;
      if (stop_cond || !serial_ok) begin
        st_reg  <= ST_IDLE;
        sda_reg <= '{data_out: 1'b1, data_oe_n: 1'b1};
      end else if (start_cond) begin
        st_reg  <= ST_ADDR;
        bit_reg <= 4'h0;
        sda_reg <= '{data_out: 1'b1, data_oe_n: 1'b1};
      end else if (scl_rise) begin
        unique case (st_reg)
          ST_ADDR, ST_CMD, ST_WDATA: begin
            sh_reg  <= sh_next;
            bit_reg <= bit_reg + 4'h1;
          end
          ST_RDATA: bit_reg <= bit_reg + 4'h1;
          ST_RACK: begin
            // Controller NACK ends the read
            st_after_reg <= sda_in ? ST_SKIP : ST_RDATA;
          end
          default: ;
        endcase
      end else if (scl_fall) begin
        unique case (st_reg)
          ST_ADDR: if (bit_reg == 4'h8) begin
            bit_reg <= 4'h0;
            if (addr_hit) begin
              sda_reg <= '{data_out: 1'b0, data_oe_n: 1'b0};
              st_reg  <= ST_ACK;
              st_after_reg <= sh_reg[0] ? ST_RDATA : ST_CMD;
              rcount_reg <= 8'h00;
            end else
              st_reg <= ST_SKIP;
          end
          ST_CMD: if (bit_reg == 4'h8) begin
            single_reg <= sh_reg[POS_CMD_SINGLE];
            ptr_reg    <= sh_reg[6:0];
            bit_reg    <= 4'h0;
            sda_reg    <= '{data_out: 1'b0, data_oe_n: 1'b0};
            st_reg     <= ST_ACK;
            st_after_reg <= ST_WDATA;
          end
          ST_WDATA: if (bit_reg == 4'h8) begin
            bit_reg <= 4'h0;
            if (ee_busy_reg || (single_reg && acking_reg)) begin
              st_reg <= ST_SKIP;
            end else begin
              sda_reg <= '{data_out: 1'b0, data_oe_n: 1'b0};
              st_reg  <= ST_ACK;
              st_after_reg <= ST_WDATA;
              ptr_reg <= ptr_reg + 7'h01;
              acking_reg <= 1'b1;
            end
          end
          ST_ACK: begin
            sda_reg <= '{data_out: 1'b1, data_oe_n: 1'b1};
            st_reg  <= st_after_reg;
            if (st_after_reg == ST_RDATA) begin
              sh_reg  <= rd_byte;
              sda_reg <= '{data_out: rd_byte[7],
                           data_oe_n: ~(rd_byte[7] == 1'b0)};
            end
            if (st_after_reg == ST_CMD) acking_reg <= 1'b0;
          end
          ST_RDATA: if (bit_reg == 4'h8) begin
            bit_reg <= 4'h0;
            sda_reg <= '{data_out: 1'b1, data_oe_n: 1'b1};
            st_reg  <= ST_RACK;
            ptr_reg <= ptr_reg + 7'h01;
            rcount_reg <= rcount_reg + 8'h01;
          end else begin
            sh_reg  <= {sh_reg[6:0], 1'b0};
            sda_reg <= '{data_out: sh_reg[6],
                         data_oe_n: sh_reg[6]};
          end
          ST_RACK: begin
            // Single read or count reached: release the bus
            if (st_after_reg == ST_SKIP || single_reg ||
                rcount_reg >= byte_cnt) begin
              st_reg <= ST_SKIP;
            end else begin
              sh_reg  <= rd_byte;
              sda_reg <= '{data_out: rd_byte[7],
                           data_oe_n: rd_byte[7]};
              st_reg  <= ST_RDATA;
            end
          end
          default: ;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Register bytes: write at the eighth rising edge of a data byte
  wire wr_take = scl_rise && !start_cond && st_reg == ST_WDATA &&
                 bit_reg == 4'h7 && !ee_busy_reg &&
                 !(single_reg && acking_reg);
  always_ff @(posedge clock_in) begin
    if (load_reg)
      regs_reg[load_idx_reg] <= (eeprom_reg[OFS_ID] == 8'h00) ?
                                factory_byte(load_idx_reg) :
                                eeprom_reg[load_idx_reg];
    else if (wr_take && ptr_reg != OFS_ID)
      regs_reg[ptr_reg] <= sh_next;
  end

  //////////////////////////////////////////////////////////////////////
  // Select pins: dual pins read as 0 while serial
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      select_out                 <= '{ctl_mode: 1'b0, select: 3'h0};
      eeprom_write_busy_flag_out <= 1'b0;
      sda_out                    <= 1'b1;
      sda_oe_n_out               <= 1'b1;
    end else begin
      select_out.ctl_mode <= !serial_ok;
      select_out.select   <= serial_ok ?
        {2'b00, dedicated_select_pin_in} :
        {scl_in, sda_in, dedicated_select_pin_in};
      eeprom_write_busy_flag_out <= ee_busy_reg;
      sda_out      <= sda_reg.data_out;
      sda_oe_n_out <= sda_reg.data_oe_n;
    end
  end
endmodule : csc_target
`default_nettype wire

// [include/csc_pkg.sv]
// Constants and carriers for the serial configuration target.
// Assumes one 100 MHz clock; pin levels already synchronous.
package csc_pkg;
  localparam int          CLK_MHZ            = 100;
  localparam int          BUS_KBPS_MAX       = 400;
  localparam logic [4:0]  ADDR_UPPER         = 5'h1B;
  localparam int          REG_BYTES          = 128;
  localparam logic [6:0]  OFS_ID             = 7'h00;
  localparam logic [6:0]  OFS_STATUS         = 7'h01;
  localparam logic [6:0]  OFS_PINCTL         = 7'h02;
  localparam logic [6:0]  OFS_BYTECOUNT      = 7'h06;
  localparam int          POS_BUSY           = 6;
  localparam int          POS_PINMODE        = 6;
  localparam int          POS_ADDR_LSB       = 0;
  localparam int          POS_CMD_SINGLE     = 7;
  localparam logic [7:0]  ID_VALUE           = 8'h81; // Arbitrary value
  localparam logic [7:0]  RST_STATUS         = 8'h00;
  localparam logic [7:0]  RST_BYTECOUNT      = 8'h40;
  // EEPROM program time in cycles (a model figure)
  localparam int          EE_WRITE_CYCLES    = 4000;

  typedef struct packed {
    logic       ctl_mode;
    logic [2:0] select;
  } csc_sel_t;

  typedef struct packed {
    logic data_out;
    logic data_oe_n;
  } csc_sda_t;
endpackage : csc_pkg

// [sim/csc_host_model.sv]
// Bus controller model: drives the clock line, shares the data line.
// Assumes a pull-up on the data line and an oversampling target.
`timescale 1ns/100ps
`default_nettype none
module csc_host_model (
  input  wire logic clock_in,
  input  wire logic dut_sda_in,
  input  wire logic dut_oe_n_in,
  output var  logic scl_out,
  output wire logic sda_out
);
  localparam int HALF = 10;
  logic rel_reg = 1'b1;
  initial scl_out = 1'b1;
  // Pull-up: a released line reads 1, never the last value
  assign sda_out = rel_reg & (dut_oe_n_in | dut_sda_in);
  task automatic wt(input int n);
    repeat (n) @(posedge clock_in);
  endtask : wt
  // Only one line moves per step, so no false start or stop
  task automatic drv(input logic c, input logic d);
    wt(HALF);
    scl_out <= c;
    rel_reg <= d;
  endtask : drv
  task automatic bit_io(input logic b, output logic seen);
    wt(2);
    rel_reg <= b;
    wt(HALF);
    scl_out <= 1'b1;
    wt(HALF);
    seen = sda_out;
    scl_out <= 1'b0;
  endtask : bit_io
  task automatic start();
    drv(1'b0, 1'b1);
    drv(1'b1, 1'b1);
    drv(1'b1, 1'b0);
    drv(1'b0, 1'b0);
  endtask : start
  task automatic stop();
    drv(1'b0, 1'b0);
    drv(1'b1, 1'b0);
    drv(1'b1, 1'b1);
  endtask : stop
  task automatic byte_tx(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask : byte_tx
  task automatic byte_rx(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, s);
  endtask : byte_rx
endmodule : csc_host_model
`default_nettype wire

// [sim/csc_target_sva.sv]
// Port checks for the serial configuration target, bound below.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module csc_target_sva
  import csc_pkg::*;
(
  input wire logic     clock_in,
  input wire logic     rst_in,
  input wire logic     scl_in,
  input wire logic     sda_out,
  input wire logic     sda_oe_n_out,
  input wire logic     dedicated_select_pin_in,
  input wire logic     vddout_grounded_in,
  input wire logic     eeprom_write_start_in,
  input wire csc_sel_t select_out,
  input wire logic     eeprom_write_busy_flag_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  localparam logic [12:0] BUSY_SPAN = 13'(EE_WRITE_CYCLES);
  logic [7:0]  up_cnt_reg;
  logic        up_done;
  logic [12:0] busy_cnt_reg;
  // Busy span is too long for a delay range: count it here
  always_ff @(posedge clock_in) begin
    if (rst_in || !eeprom_write_busy_flag_out) busy_cnt_reg <= 13'h0000;
    else busy_cnt_reg <= busy_cnt_reg + 13'h0001;
  end
  // Image load after reset may hold the selector
  assign up_done = up_cnt_reg == 8'hA0;
  always_ff @(posedge clock_in) begin
    if (rst_in) up_cnt_reg <= 8'h00;
    else if (!up_done) up_cnt_reg <= up_cnt_reg + 8'h01;
  end
  ////////////////////////////////////////
  chk_reset_quiet: assert property (disable iff (1'b0)
    rst_in |=> sda_oe_n_out && select_out == '0
      && !eeprom_write_busy_flag_out) else $error("not idle in reset");
  chk_low_only: assert property (!sda_oe_n_out |-> !sda_out)
    else $error("data driven high");
  chk_sda_clk_low: assert property ($changed(sda_oe_n_out) |-> !scl_in)
    else $error("data moved while clock high");
  chk_ack_delay: assert property ($fell(sda_oe_n_out) |->
    $past(scl_in, 2) || $past(scl_in, 3) || $past(scl_in, 4)
      || $past(scl_in, 5)) else $error("drive not after clock fall");
  chk_sel_serial: assert property (!select_out.ctl_mode |->
    select_out.select[2:1] == 2'b00) else $error("dual selects not 0");
  chk_sel_follow: assert property ((up_done && !select_out.ctl_mode
    && $stable(dedicated_select_pin_in))[*3] |->
      select_out.select[0] == dedicated_select_pin_in)
    else $error("select does not follow pin");
  chk_busy_rise: assert property (eeprom_write_start_in && up_done
    && !eeprom_write_busy_flag_out |-> ##[1:3] eeprom_write_busy_flag_out)
    else $error("busy not raised");
  chk_busy_span: assert property ($fell(eeprom_write_busy_flag_out) |->
    busy_cnt_reg == BUSY_SPAN)
    else $error("busy span wrong");
  chk_busy_limit: assert property (eeprom_write_busy_flag_out |->
    busy_cnt_reg < BUSY_SPAN)
    else $error("busy held too long");
  chk_ctl_silent: assert property ((select_out.ctl_mode
    && !vddout_grounded_in)[*2] |-> sda_oe_n_out)
    else $error("serial active in control mode");
  cov_busy: cover property ($rose(eeprom_write_busy_flag_out));
  cov_ack: cover property ($fell(sda_oe_n_out));
  cov_ctl: cover property (select_out.ctl_mode && vddout_grounded_in);
endmodule : csc_target_sva
bind csc_target csc_target_sva u_sva (
  .clock_in(clock_in), .rst_in(rst_in), .scl_in(scl_in),
  .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
  .dedicated_select_pin_in(dedicated_select_pin_in),
  .vddout_grounded_in(vddout_grounded_in),
  .eeprom_write_start_in(eeprom_write_start_in),
  .select_out(select_out),
  .eeprom_write_busy_flag_out(eeprom_write_busy_flag_out));
`default_nettype wire

// [sim/csc_target_tb.sv]
// Self-checking bench for the serial configuration target.
// Assumes the controller model and bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module csc_target_tb
  import csc_pkg::*;
;
  logic       clock_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       ded_reg = 1'b0;
  logic       gnd_reg = 1'b0;
  logic       ee_reg = 1'b0;
  wire logic  scl, sda, sda_drv, sda_oe_n, busy;
  csc_sel_t   sel;
  int         mismatches = 0;
  int         samples_checked = 0;
  logic [7:0] q[$];
  logic       ack;
  always #5 clock_in = ~clock_in;
  csc_target u_dut (.clock_in(clock_in), .rst_in(rst_in), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_drv), .sda_oe_n_out(sda_oe_n),
    .dedicated_select_pin_in(ded_reg), .vddout_grounded_in(gnd_reg),
    .eeprom_write_start_in(ee_reg), .select_out(sel),
    .eeprom_write_busy_flag_out(busy));
  csc_host_model u_host (.clock_in(clock_in), .dut_sda_in(sda_drv),
    .dut_oe_n_in(sda_oe_n), .scl_out(scl), .sda_out(sda));
  ////////////////////////////////////////
  task automatic wt(input int n);
    repeat (n) @(posedge clock_in);
  endtask : wt
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [1:0] lo, input logic [7:0] cmd,
                    input logic [7:0] d[$], output logic ok);
    logic a;
    u_host.start();
    u_host.byte_tx({ADDR_UPPER, lo, 1'b0}, ok);
    u_host.byte_tx(cmd, a);
    foreach (d[i]) begin
      u_host.byte_tx(d[i], a);
      ok = ok & a;
    end
    u_host.stop();
  endtask : wr
  task automatic rd(input logic [7:0] cmd, input int n);
    logic       a;
    logic [7:0] b;
    q = {};
    u_host.start();
    u_host.byte_tx({ADDR_UPPER, 2'b00, 1'b0}, a);
    u_host.byte_tx(cmd, a);
    u_host.start();
    u_host.byte_tx({ADDR_UPPER, 2'b00, 1'b1}, a);
    for (int i = 0; i < n; i++) begin
      u_host.byte_rx(i == n - 1, b);
      q.push_back(b);
    end
    u_host.stop();
  endtask : rd
  task automatic ee_go();
    ee_reg <= 1'b1;
    wt(1);
    ee_reg <= 1'b0;
    wt(3);
    chk("busy set", {7'h00, busy}, 8'h01);
  endtask : ee_go
  task automatic ee_wait();
    for (int n = 0; n < 5000 && busy !== 1'b0; n++) wt(1);
    chk("busy clear", {7'h00, busy}, 8'h00);
  endtask : ee_wait
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  ////////////////////////////////////////
  initial begin
    wt(60000);
    mismatches++;
    final_report();
  end
  initial begin
    wt(5);
    rst_in <= 1'b0;
    wt(140);
    chk("select idle", {4'h0, sel}, 8'h00);
    ded_reg <= 1'b1;
    wt(4);
    chk("select one", {4'h0, sel}, 8'h01);
    $display("test select done");
    rd(8'h80, 1);
    chk("id byte", q[0], ID_VALUE);
    rd(8'h86, 1);
    chk("count default", q[0], RST_BYTECOUNT);
    wr(2'b00, 8'h90, '{8'hA5}, ack);
    chk("byte write ack", {7'h00, ack}, 8'h01);
    rd(8'h90, 1);
    chk("byte readback", q[0], 8'hA5);
    wr(2'b00, 8'h86, '{8'h03}, ack);
    wr(2'b00, 8'h20, '{8'h11, 8'h22, 8'h33}, ack);
    rd(8'h20, 3);
    foreach (q[i]) chk("block byte", q[i], 8'(8'h11 * (i + 1)));
    $display("test transfers done");
    wr(2'b01, 8'h91, '{8'h5A}, ack);
    chk("foreign address", {7'h00, ack}, 8'h00);
    wr(2'b00, 8'h81, '{8'h01}, ack);
    wr(2'b01, 8'h81, '{8'h00}, ack);
    chk("moved address", {7'h00, ack}, 8'h01);
    $display("test address done");
    ee_go();
    wr(2'b00, 8'h90, '{8'h77}, ack);
    chk("write while busy", {7'h00, ack}, 8'h00);
    rd(8'h81, 1);
    chk("busy bit", q[0] & 8'h40, 8'h40);
    ee_wait();
    rd(8'h90, 1);
    chk("refused write", q[0], 8'hA5);
    $display("test eeprom done");
    wr(2'b00, 8'h82, '{8'h40}, ack);
    wt(4);
    chk("mode unstored", {7'h00, sel.ctl_mode}, 8'h00);
    ee_go();
    ee_wait();
    wt(4);
    chk("control select", {4'h0, sel}, 8'h0F);
    wr(2'b00, 8'h93, '{8'h00}, ack);
    chk("serial off", {7'h00, ack}, 8'h00);
    gnd_reg <= 1'b1;
    wt(4);
    wr(2'b00, 8'h93, '{8'h00}, ack);
    chk("serial grounded", {7'h00, ack}, 8'h01);
    $display("test pin mode done");
    final_report();
  end
endmodule : csc_target_tb
`default_nettype wire
